//--- design/asqi_pkg.sv
// Purpose: Shared constants and carriers for the sequencer interrupt block
// Assumes: 32-bit AXI4-Lite register access, four sample sequencers
// Notes:   Offsets are byte addresses
package asqi_pkg;

    localparam int NSEQ   = 4;
    localparam int SMP_W  = 10;
    localparam int ADDR_W = 12;
    localparam int EVT_W  = 8;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_RAW = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_FWD = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_ISC = 12'h00C;
    localparam logic [ADDR_W-1:0] OFS_OVF = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_EVT = 12'h040;
    localparam logic [ADDR_W-1:0] OFS_EVM = 12'h044;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and field positions
    localparam logic [NSEQ-1:0]  RST_FWD = 4'h0;
    localparam logic [NSEQ-1:0]  RST_RAW = 4'h0;
    localparam logic [NSEQ-1:0]  RST_OVF = 4'h0;
    localparam logic [EVT_W-1:0] RST_EVT = 8'h00;
    localparam logic [EVT_W-1:0] RST_EVM = 8'h00;
    localparam int EVT_DONE_LSB = 0;
    localparam int EVT_OVF_LSB  = 4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic             wr;
        logic [SMP_W-1:0] data;
    } asqi_sample_t;

    typedef struct packed {
        logic done;
        logic step_irq_enable;
    } asqi_done_t;

endpackage

//--- design/asqi_top.sv
// Purpose: Sequencer interrupt forwarding, status/clear, overflow flags
// Assumes: Sample and FIFO-full inputs synchronous to ref_clk
// Notes:   AXI4-Lite slave, one write and one read in flight
`timescale 1ns/10ps
`default_nettype none

module asqi_top (
    input  wire logic                                   ref_clk,
    input  wire logic                                   rst,
    input  wire asqi_pkg::asqi_done_t   [3:0]           done_in,
    input  wire asqi_pkg::asqi_sample_t [3:0]           sample_in,
    input  wire logic                   [3:0]           fifo_full,
    output var  logic                   [3:0]           fifo_push,
    output var  logic [3:0][asqi_pkg::SMP_W-1:0]        fifo_data,
    output var  logic                   [3:0]           seq_irq,
    output var  logic                                   irq,
    input  wire logic [asqi_pkg::ADDR_W-1:0]            s_axi_awaddr,
    input  wire logic                                   s_axi_awvalid,
    output var  logic                                   s_axi_awready,
    input  wire logic [31:0]                            s_axi_wdata,
    input  wire logic [3:0]                             s_axi_wstrb,
    input  wire logic                                   s_axi_wvalid,
    output var  logic                                   s_axi_wready,
    output var  logic [1:0]                             s_axi_bresp,
    output var  logic                                   s_axi_bvalid,
    input  wire logic                                   s_axi_bready,
    input  wire logic [asqi_pkg::ADDR_W-1:0]            s_axi_araddr,
    input  wire logic                                   s_axi_arvalid,
    output var  logic                                   s_axi_arready,
    output var  logic [31:0]                            s_axi_rdata,
    output var  logic [1:0]                             s_axi_rresp,
    output var  logic                                   s_axi_rvalid,
    input  wire logic                                   s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode helper
    function automatic logic hit(
        input logic [asqi_pkg::ADDR_W-1:0] addr,
        input logic [asqi_pkg::ADDR_W-1:0] ofs
    );
        hit = (addr[asqi_pkg::ADDR_W-1:2] == ofs[asqi_pkg::ADDR_W-1:2]);
    endfunction

    function automatic logic mapped(
        input logic [asqi_pkg::ADDR_W-1:0] addr
    );
        mapped = hit(addr, asqi_pkg::OFS_RAW) | hit(addr, asqi_pkg::OFS_FWD)
               | hit(addr, asqi_pkg::OFS_ISC) | hit(addr, asqi_pkg::OFS_OVF)
               | hit(addr, asqi_pkg::OFS_EVT) | hit(addr, asqi_pkg::OFS_EVM);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [3:0]                       raw_ff;
    logic [3:0]                       fwd_ff;
    logic [3:0]                       ovf_ff;
    logic [asqi_pkg::EVT_W-1:0]       evt_ff;
    logic [asqi_pkg::EVT_W-1:0]       evm_ff;
    logic [3:0]                       seq_irq_ff;
    logic                             irq_ff;
    logic [3:0]                       push_ff;
    logic [3:0][asqi_pkg::SMP_W-1:0]  data_ff;

    logic                             aw_hold_ff;
    logic                             w_hold_ff;
    logic                             aw_rdy_ff;
    logic                             w_rdy_ff;
    logic [asqi_pkg::ADDR_W-1:0]      wr_addr_ff;
    logic [31:0]                      wr_data_ff;
    logic [3:0]                       wr_strb_ff;
    logic                             bvalid_ff;
    logic [1:0]                       bresp_ff;
    logic                             ar_rdy_ff;
    logic                             rvalid_ff;
    logic [31:0]                      rdata_ff;
    logic [1:0]                       rresp_ff;

    ////////////////////////////////////////////////////////////////////////
    // Write channel handshakes
    wire aw_take  = s_axi_awvalid & aw_rdy_ff;
    wire w_take   = s_axi_wvalid & w_rdy_ff;
    // Readys stay low from take to fire: one write in flight
    wire wr_fire  = aw_hold_ff & w_hold_ff & ~bvalid_ff;
    wire nxt_aw_hold = (aw_hold_ff | aw_take) & ~wr_fire;
    wire nxt_w_hold  = (w_hold_ff | w_take) & ~wr_fire;
    wire nxt_bvalid  = wr_fire | (bvalid_ff & ~s_axi_bready);
    // Flags live in byte lane 0 only
    wire wr_lo    = wr_fire & wr_strb_ff[0];

    wire wr_fwd   = wr_lo & hit(wr_addr_ff, asqi_pkg::OFS_FWD);
    wire wr_isc   = wr_lo & hit(wr_addr_ff, asqi_pkg::OFS_ISC);
    wire wr_ovf   = wr_lo & hit(wr_addr_ff, asqi_pkg::OFS_OVF);
    wire wr_evm   = wr_lo & hit(wr_addr_ff, asqi_pkg::OFS_EVM);

    ////////////////////////////////////////////////////////////////////////
    // Read channel handshakes
    wire rd_take    = s_axi_arvalid & ar_rdy_ff;
    wire nxt_rvalid = rd_take | (rvalid_ff & ~s_axi_rready);
    wire rd_evt     = rd_take & hit(s_axi_araddr, asqi_pkg::OFS_EVT);
    wire rd_narrow  = hit(s_axi_araddr, asqi_pkg::OFS_FWD)
                    | hit(s_axi_araddr, asqi_pkg::OFS_ISC)
                    | hit(s_axi_araddr, asqi_pkg::OFS_OVF);

    ////////////////////////////////////////////////////////////////////////
    // Flag logic
    logic [3:0] done_set;
    logic [3:0] ovf_set;
    logic [3:0] push_ok;
    logic [3:0][asqi_pkg::SMP_W-1:0] smp_data;

    for (genvar i = 0; i < asqi_pkg::NSEQ; i++) begin : g_seq
        assign done_set[i] = done_in[i].done & done_in[i].step_irq_enable;
        // Full-FIFO write is dropped here, never pushed
        assign ovf_set[i]  = sample_in[i].wr & fifo_full[i];
        assign push_ok[i]  = sample_in[i].wr & ~fifo_full[i];
        assign smp_data[i] = sample_in[i].data;
    end

    // Zero bits in the written value leave flags untouched
    wire [3:0] isc_clr = wr_isc ? wr_data_ff[3:0] : 4'h0;
    wire [3:0] ovf_clr = wr_ovf ? wr_data_ff[3:0] : 4'h0;

    // Clear hits the raw flag whatever the forward enable says
    wire [3:0] raw_kept = raw_ff & ~isc_clr;
    // Set is ORed in last so a same-cycle clear cannot lose an event
    wire [3:0] nxt_raw  = raw_kept | done_set;
    wire [3:0] ovf_kept = ovf_ff & ~ovf_clr;
    wire [3:0] nxt_ovf  = ovf_kept | ovf_set;
    wire [3:0] nxt_fwd = wr_fwd ? wr_data_ff[3:0] : fwd_ff;
    wire [3:0] masked  = raw_ff & fwd_ff;

    wire [asqi_pkg::EVT_W-1:0] evt_set = {ovf_set, done_set};
    wire [asqi_pkg::EVT_W-1:0] evt_clr = rd_evt ? 8'hFF : 8'h00;
    wire [asqi_pkg::EVT_W-1:0] nxt_evt = (evt_ff & ~evt_clr) | evt_set;
    wire [asqi_pkg::EVT_W-1:0] nxt_evm =
        wr_evm ? wr_data_ff[asqi_pkg::EVT_W-1:0] : evm_ff;

    ////////////////////////////////////////////////////////////////////////
    // Read mux; upper bits of narrow registers read as zero
    // Unmapped offsets answer SLVERR with zero data
    wire [31:0] rd_mux =
        hit(s_axi_araddr, asqi_pkg::OFS_RAW) ? {28'h000_0000, raw_ff} :
        hit(s_axi_araddr, asqi_pkg::OFS_FWD) ? {28'h000_0000, fwd_ff} :
        hit(s_axi_araddr, asqi_pkg::OFS_ISC) ? {28'h000_0000, masked} :
        hit(s_axi_araddr, asqi_pkg::OFS_OVF) ? {28'h000_0000, ovf_ff} :
        hit(s_axi_araddr, asqi_pkg::OFS_EVT) ? {24'h00_0000, evt_ff}  :
        hit(s_axi_araddr, asqi_pkg::OFS_EVM) ? {24'h00_0000, evm_ff}  :
        32'h0000_0000;
    wire [1:0] rd_resp = mapped(s_axi_araddr) ? asqi_pkg::RESP_OKAY
                                              : asqi_pkg::RESP_SLVERR;
    wire [1:0] wr_resp = mapped(wr_addr_ff) ? asqi_pkg::RESP_OKAY
                                            : asqi_pkg::RESP_SLVERR;

    ////////////////////////////////////////////////////////////////////////
    // Flag registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            raw_ff <= asqi_pkg::RST_RAW;
            fwd_ff <= asqi_pkg::RST_FWD;
            ovf_ff <= asqi_pkg::RST_OVF;
            evt_ff <= asqi_pkg::RST_EVT;
            evm_ff <= asqi_pkg::RST_EVM;
        end else begin
            raw_ff <= nxt_raw;
            fwd_ff <= nxt_fwd;
            ovf_ff <= nxt_ovf;
            evt_ff <= nxt_evt;
            evm_ff <= nxt_evm;
        end
    end

    // Outputs; interrupt lines are levels, seq_irq one cycle behind the flags, irq in step with evt_ff and evm_ff
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            seq_irq_ff <= 4'h0;
            irq_ff     <= 1'b0;
            push_ff    <= 4'h0;
            data_ff    <= '0;
        end else begin
            seq_irq_ff <= masked;
            irq_ff     <= |(nxt_evt & nxt_evm);
            push_ff    <= push_ok;
            data_ff    <= smp_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus slave registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            aw_rdy_ff  <= 1'b0;
            w_rdy_ff   <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= asqi_pkg::RESP_OKAY;
        end else begin
            aw_hold_ff <= nxt_aw_hold;
            w_hold_ff  <= nxt_w_hold;
            aw_rdy_ff  <= ~nxt_aw_hold;
            w_rdy_ff   <= ~nxt_w_hold;
            bvalid_ff  <= nxt_bvalid;
            if (wr_fire) begin
                bresp_ff <= wr_resp;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_addr_ff <= '0;
            wr_data_ff <= 32'h0000_0000;
            wr_strb_ff <= 4'h0;
        end else begin
            if (aw_take) begin
                wr_addr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                wr_data_ff <= s_axi_wdata;
                wr_strb_ff <= s_axi_wstrb;
            end
        end
    end

    // Reads of the event register clear it; set still wins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ar_rdy_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= asqi_pkg::RESP_OKAY;
        end else begin
            ar_rdy_ff <= ~nxt_rvalid;
            rvalid_ff <= nxt_rvalid;
            if (rd_take) begin
                rdata_ff <= rd_mux;
                rresp_ff <= rd_resp;
            end
        end
    end

    assign fifo_push     = push_ff;
    assign fifo_data     = data_ff;
    assign seq_irq       = seq_irq_ff;
    assign irq           = irq_ff;
    assign s_axi_awready = aw_rdy_ff;
    assign s_axi_wready  = w_rdy_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = ar_rdy_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_wr_fire;
        wr_fire;
    endsequence

    sequence s_bresp_up;
        s_axi_bvalid ##1 (s_axi_bvalid || $past(s_axi_bready));
    endsequence

    a_bus_wr_resp: assert property (s_wr_fire |=> s_bresp_up)
        else $error("write response did not follow write");

    a_irq_gate_mask: assert property (
        ##1 seq_irq == $past(raw_ff & fwd_ff))
        else $error("sequencer interrupt not raw AND enable");

    a_isc_read_and: assert property (
        rd_take && hit(s_axi_araddr, asqi_pkg::OFS_ISC)
        |=> s_axi_rvalid && s_axi_rdata[3:0] == $past(raw_ff & fwd_ff))
        else $error("status read is not raw AND enable");

    a_irq_level_hold: assert property (
        (raw_ff & fwd_ff) != 4'h0 [*2] |-> seq_irq != 4'h0)
        else $error("interrupt dropped while condition held");

    a_isc_clear_raw: assert property (
        (isc_clr & ~done_set) != 4'h0
        |=> (raw_ff & $past(isc_clr & ~done_set)) == 4'h0)
        else $error("write one did not clear raw flag");

    a_poll_clear: assert property (
        (isc_clr & ~fwd_ff & ~done_set) != 4'h0
        |=> (raw_ff & $past(isc_clr & ~fwd_ff & ~done_set)) == 4'h0)
        else $error("masked raw flag not cleared");

    a_ovf_drop: assert property (
        ovf_set != 4'h0 |=> (fifo_push & $past(ovf_set)) == 4'h0)
        else $error("write to full fifo was pushed");

    a_ovf_sticky: assert property (
        ##1 ($past(ovf_ff & ~ovf_clr | ovf_set) & ~ovf_ff) == 4'h0)
        else $error("overflow flag lost without clear");

    a_ovf_w1c: assert property (
        ovf_clr != 4'h0 && ovf_set == 4'h0
        |=> ovf_ff == ($past(ovf_ff) & ~$past(ovf_clr)))
        else $error("overflow clear touched wrong bits");

    a_rsvd_bits: assert property (
        rd_take && rd_narrow |=> s_axi_rdata[31:4] == 28'h000_0000)
        else $error("upper bits of narrow register not zero");

    a_done_sets: assert property (
        done_set != 4'h0 |=> (raw_ff & $past(done_set)) == $past(done_set))
        else $error("completion did not set raw flag");

    a_zero_write: assert property (
        wr_isc && wr_data_ff[3:0] == 4'h0
        |=> raw_ff == $past(raw_ff | done_set))
        else $error("zero write changed raw flags");

    a_set_wins: assert property (
        (done_set & isc_clr) != 4'h0
        |=> (raw_ff & $past(done_set & isc_clr)) == $past(done_set & isc_clr))
        else $error("clear beat a same-cycle set");

endmodule

`default_nettype wire

//--- sim/asqi_fifo_model.sv
// Purpose: Behavioural result FIFO standing beside one sequencer
// Assumes: Pushes come from the block under test
// Notes:   Keeps only a fill count, the newest stored word and a full-push flag
`timescale 1ns/10ps
`default_nettype none

module asqi_fifo_model #(
    parameter int DEPTH = 2
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       push,
    input  wire logic [9:0] data,
    input  wire logic       drain,
    output var  logic       full,
    output var  logic [9:0] last_ff,
    output var  logic       bad_ff
);
    int cnt_ff;

    assign full = (cnt_ff >= DEPTH);

    // A push into a full FIFO is kept out and flagged for the bench
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_ff  <= 0;
            last_ff <= 10'h000;
            bad_ff  <= 1'b0;
        end else if (drain) begin
            cnt_ff <= 0;
        end else if (push && full) begin
            bad_ff <= 1'b1;
        end else if (push) begin
            cnt_ff  <= cnt_ff + 1;
            last_ff <= data;
        end
    end
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Purpose: Self-checking bench for the sequencer interrupt block
// Assumes: Registers answer over AXI4-Lite, FIFO model depth two
// Notes:   Every wait is bounded and ends in the closing report
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic                         ref_clk;
    logic                         rst = 1'b1;
    asqi_pkg::asqi_done_t   [3:0] done_in = '0;
    asqi_pkg::asqi_sample_t [3:0] sample_in = '0;
    logic [3:0]                   drain = '0;
    logic [3:0]                   wstrb = 4'hF;
    logic [3:0]                   fifo_full, fifo_push, seq_irq, bad;
    logic [3:0][9:0]              fifo_data, last;
    logic                         irq, awready, wready, bvalid;
    logic                         arready, rvalid;
    logic                         watch = 1'b0, awvalid = 1'b0;
    logic                         wvalid = 1'b0, bready = 1'b0;
    logic                         arvalid = 1'b0, rready = 1'b0;
    logic [11:0]                  awaddr = '0, araddr = '0;
    logic [31:0]                  wdata = '0, rdata;
    logic [1:0]                   bresp, rresp;
    int                           failures, checks_done, dips;

    asqi_top asqi_top_inst (
        .ref_clk(ref_clk), .rst(rst), .done_in(done_in),
        .sample_in(sample_in), .fifo_full(fifo_full),
        .fifo_push(fifo_push), .fifo_data(fifo_data), .seq_irq(seq_irq),
        .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    for (genvar g = 0; g < 4; g++) begin : g_fifo
        asqi_fifo_model asqi_fifo_model_inst (
            .ref_clk(ref_clk), .rst(rst), .push(fifo_push[g]),
            .data(fifo_data[g]), .drain(drain[g]), .full(fifo_full[g]),
            .last_ff(last[g]), .bad_ff(bad[g])
        );
    end

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Held completion spans a clear; any dip means the clear won
    always @(posedge ref_clk) begin
        if (watch && seq_irq[3] !== 1'b1) dips++;
    end

    ////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, s);
            failures++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                          input logic [1:0] er = asqi_pkg::RESP_OKAY);
        int k;
        k = 0;
        @(posedge ref_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready) && k < 64);
        bready <= 1'b0;
        if (k >= 64) begin
            $display("unexpected bvalid timeout expected 1 seen 0");
            failures++;
            final_report();
        end
        chk("bresp", 32'(bresp), 32'(er));
    endtask

    task automatic rd_chk(input string n, input logic [11:0] a,
                          input logic [31:0] e,
                          input logic [1:0] er = asqi_pkg::RESP_OKAY,
                          input logic [31:0] m = 32'hFFFF_FFFF);
        int k;
        k = 0;
        @(posedge ref_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready) && k < 64);
        rready <= 1'b0;
        if (k >= 64) begin
            $display("unexpected rvalid timeout expected 1 seen 0");
            failures++;
            final_report();
        end
        chk(n, rdata & m, e);
        chk("rresp", 32'(rresp), 32'(er));
    endtask

    task automatic pulse_done(input logic [3:0] d, input logic [3:0] ie);
        for (int i = 0; i < 4; i++) done_in[i] <= {d[i], ie[i]};
        @(posedge ref_clk);
        done_in <= '0;
        cyc(3);
    endtask

    // Spaced so the model's fill count settles before the next write
    task automatic put(input int k);
        for (int i = 0; i < 4; i++) sample_in[i] <= {1'b1, 10'(16*i+k)};
        @(posedge ref_clk);
        sample_in <= '0;
        cyc(3);
    endtask

    ////////////////////////////////////////
    initial begin
        cyc(16);
        rst <= 1'b0;
        cyc(2);
        rd_chk("fwd", asqi_pkg::OFS_FWD, 32'h0000_0000);
        rd_chk("isc", asqi_pkg::OFS_ISC, 32'h0000_0000);
        rd_chk("ovf", asqi_pkg::OFS_OVF, 32'h0000_0000);
        rd_chk("gap", 12'h020, 32'h0000_0000, asqi_pkg::RESP_SLVERR);
        axi_wr(12'h020, 32'h0000_000F, asqi_pkg::RESP_SLVERR);
        wstrb <= 4'hE;
        axi_wr(asqi_pkg::OFS_FWD, 32'h0000_000F);
        wstrb <= 4'hF;
        rd_chk("fwd", asqi_pkg::OFS_FWD, 32'h0000_0000);
        chk("seq_irq", 32'(seq_irq), 32'h0000_0000);
        $display("test reset and decode done");

        pulse_done(4'hF, 4'hB);
        rd_chk("raw", asqi_pkg::OFS_RAW, 32'h0000_000B);
        rd_chk("isc", asqi_pkg::OFS_ISC, 32'h0000_0000);
        chk("seq_irq", 32'(seq_irq), 32'h0000_0000);
        axi_wr(asqi_pkg::OFS_FWD, 32'h0000_0005);
        rd_chk("isc", asqi_pkg::OFS_ISC, 32'h0000_0001);
        cyc(8);
        chk("seq_irq", 32'(seq_irq), 32'h0000_0001);
        axi_wr(asqi_pkg::OFS_RAW, 32'h0000_0000);
        axi_wr(asqi_pkg::OFS_ISC, 32'h0000_0000);
        rd_chk("raw", asqi_pkg::OFS_RAW, 32'h0000_000B);
        axi_wr(asqi_pkg::OFS_ISC, 32'h0000_0002);
        rd_chk("raw", asqi_pkg::OFS_RAW, 32'h0000_0009);
        axi_wr(asqi_pkg::OFS_ISC, 32'h0000_0001);
        rd_chk("raw", asqi_pkg::OFS_RAW, 32'h0000_0008);
        chk("seq_irq", 32'(seq_irq), 32'h0000_0000);
        $display("test completion flags done");

        put(1);
        put(2);
        put(3);
        for (int i = 0; i < 4; i++) begin
            chk("last", 32'(last[i]), 32'(16*i+2));
        end
        chk("bad", 32'(bad), 32'h0000_0000);
        cyc(20);
        rd_chk("ovf", asqi_pkg::OFS_OVF, 32'h0000_000F);
        axi_wr(asqi_pkg::OFS_OVF, 32'h0000_0000);
        axi_wr(asqi_pkg::OFS_OVF, 32'h0000_0005);
        rd_chk("ovf", asqi_pkg::OFS_OVF, 32'h0000_000A);
        drain <= 4'hF;
        cyc(1);
        drain <= 4'h0;
        $display("test overflow done");

        axi_wr(asqi_pkg::OFS_FWD, 32'h0000_0008);
        done_in[3] <= 2'h3;
        cyc(4);
        watch <= 1'b1;
        axi_wr(asqi_pkg::OFS_ISC, 32'h0000_0008);
        cyc(3);
        watch <= 1'b0;
        done_in[3] <= 2'h0;
        chk("dips", 32'(dips), 32'h0000_0000);
        $display("test set against clear done");

        chk("irq", 32'(irq), 32'h0000_0000);
        rd_chk("evt", asqi_pkg::OFS_EVT, 32'h0000_00F0,
               asqi_pkg::RESP_OKAY, 32'h0000_00F0);
        axi_wr(asqi_pkg::OFS_EVM, 32'h0000_0001);
        pulse_done(4'h2, 4'h2);
        chk("irq", 32'(irq), 32'h0000_0000);
        pulse_done(4'h1, 4'h1);
        chk("irq", 32'(irq), 32'h0000_0001);
        rd_chk("evt", asqi_pkg::OFS_EVT, 32'h0000_0003);
        cyc(2);
        chk("irq", 32'(irq), 32'h0000_0000);
        rd_chk("evm", asqi_pkg::OFS_EVM, 32'h0000_0001);
        $display("test interrupt line done");
        final_report();
    end
endmodule
`default_nettype wire
